// file: design/smp_dev_port.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: Answer only address 010110x, x from pin
// R2: Upper six address bits are hardwired
// R3: Address pin doubles as open-drain output
// R4: Slave only, four byte protocols
// R5: 7-bit address, 8-bit register, 8-bit data
// R6: Every byte shifted MSB first
// R7: Write commits only after complete sequence
// R8: Combined read returns one byte, host NACKs
// R9: Pointer-only write loads pointer, no data
// R10: Short read uses pointer, leaves it unchanged
// R11: Pointer keeps value between transactions
// R12: One data byte, no auto-increment
// R13: Only defined register addresses accepted
// R14: Bad address/register/protocol: NACK, go idle
// R15: General call never acknowledged
// R16: START then STOP resets to idle
// R17: Never stretch clock, tolerate others
// R18: Drive ACKs and read bits, else release
// R19: Register byte also loads pointer
module smp_dev_port #(
   parameter int RESET_PULSE_CYC = smp_pkg::RST_PULSE_CYC
) (
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   smp_link_if.device      lnk,
   output logic [7:0]      reg_addr,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr,
   output logic [7:0]      reg_wr_addr,
   output logic [7:0]      reg_wr_data,
   output logic            addr_bit,
   input  wire logic       pulse_req,
   input  wire logic       alert_in,
   input  wire logic       chain_mode,
   input  wire logic       chain_val
);

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_REG,
      ST_REG_ACK,
      ST_DATA,
      ST_DATA_ACK,
      ST_OVER,
      ST_RD,
      ST_RD_ACK
   } smp_dst_type;

   // Link-clock domain
   smp_dst_type st_r;
   logic [2:0]  cnt_r;
   logic [7:0]  sh_r;
   logic [7:0]  tx_r;
   logic [7:0]  ptr_r;
   logic [7:0]  wdata_r;
   logic [7:0]  byte_in;
   logic        rw_r;
   logic        arm_r;
   logic        ptr_tgl_r;
   logic        start_seen_r;
   logic        start_tgl_r;
   logic        stop_tgl_r;
   logic        sda_oe_r;
   // System clock domain
   logic [2:0]  stop_s_r;
   logic [2:0]  start_s_r;
   logic [2:0]  ptr_s_r;
   logic [1:0]  arm_s_r;
   logic [1:0]  pin_s_r;
   logic [1:0]  cap_cnt_r;
   logic        cap_done_r;
   logic        a0_r;
   logic        done_r;
   logic        reg_wr_r;
   logic [7:0]  wr_addr_r;
   logic [7:0]  wr_data_r;
   logic [7:0]  reg_addr_r;
   logic [7:0]  rd_word_r;
   logic [19:0] pulse_cnt_r;
   logic        pin_oe_r;

   // Byte as it completes on this clock edge
   assign byte_in = {sh_r[6:0], lnk.sda};

   // START: data falls while clock high
   always_ff @(negedge lnk.sda or posedge sys_rst) begin
      if (sys_rst) begin
         start_tgl_r <= 1'b0;
      end else if (lnk.scl) begin
         start_tgl_r <= ~start_tgl_r;
      end
   end

   // STOP: data rises while clock high
   always_ff @(posedge lnk.sda or posedge sys_rst) begin
      if (sys_rst) begin
         stop_tgl_r <= 1'b0;
      end else if (lnk.scl) begin
         stop_tgl_r <= ~stop_tgl_r;
      end
   end

   // Slave state machine, samples data on rising clock
   always_ff @(posedge lnk.scl or posedge sys_rst) begin
      if (sys_rst) begin
         st_r         <= ST_IDLE;
         cnt_r        <= 3'h0;
         sh_r         <= 8'h00;
         tx_r         <= 8'h00;
         rw_r         <= 1'b0;
         arm_r        <= 1'b0;
         ptr_r        <= smp_pkg::PTR_RST;
         ptr_tgl_r    <= 1'b0;
         wdata_r      <= 8'h00;
         start_seen_r <= 1'b0;
      end else if (start_tgl_r != start_seen_r) begin
         // First bit after any START, repeated or not
         start_seen_r <= start_tgl_r;
         st_r         <= ST_ADDR;
         sh_r         <= {7'h00, lnk.sda};
         cnt_r        <= 3'h1;
         arm_r        <= 1'b0;
      end else begin
         case (st_r)
            ST_ADDR, ST_REG, ST_DATA: begin
               sh_r  <= byte_in; // R6
               cnt_r <= cnt_r + 3'h1;
               if (cnt_r == smp_pkg::BIT_LAST) begin
                  st_r <= ST_IDLE; // R14
                  if (st_r == ST_ADDR &&
                      byte_in[7:1] == {smp_pkg::SLV_ADDR_HI, a0_r}) begin
                     rw_r <= byte_in[0]; // R1 R2 R15
                     st_r <= ST_ADDR_ACK;
                  end
                  if (st_r == ST_REG && smp_pkg::reg_valid(byte_in)) begin
                     ptr_r     <= byte_in; // R9 R13 R19
                     ptr_tgl_r <= ~ptr_tgl_r;
                     st_r      <= ST_REG_ACK;
                  end
                  if (st_r == ST_DATA) begin
                     wdata_r <= byte_in; // R5
                     st_r    <= ST_DATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               cnt_r <= 3'h0;
               if (rw_r) begin
                  tx_r <= rd_word_r; // R10 R11
                  st_r <= ST_RD;
               end else begin
                  st_r <= ST_REG;
               end
            end
            ST_REG_ACK: begin
               cnt_r <= 3'h0;
               st_r  <= ST_DATA;
            end
            ST_DATA_ACK: begin
               cnt_r <= 3'h0;
               arm_r <= 1'b1; // R7
               st_r  <= ST_OVER;
            end
            ST_OVER: begin
               // The STOP's own clock rise keeps the write; a later bit drops it
               cnt_r <= 3'h1;
               if (cnt_r != 3'h0) begin
                  arm_r <= 1'b0; // R12 R14
               end
            end
            ST_RD: begin
               tx_r  <= {tx_r[6:0], 1'b0};
               cnt_r <= cnt_r + 3'h1;
               if (cnt_r == smp_pkg::BIT_LAST) begin
                  st_r <= ST_RD_ACK;
               end
            end
            default: st_r <= ST_IDLE; // R8 R4
         endcase
      end
   end

   // Data drive on falling clock; clock itself is never held
   always_ff @(negedge lnk.scl or posedge sys_rst) begin
      if (sys_rst) begin
         sda_oe_r <= 1'b0;
      end else begin
         sda_oe_r <= (st_r == ST_ADDR_ACK) || (st_r == ST_REG_ACK) ||
                     (st_r == ST_DATA_ACK) ||
                     (st_r == ST_RD && !tx_r[7]); // R18 R17
      end
   end

   // Crossings into the system clock
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         stop_s_r  <= 3'h0;
         start_s_r <= 3'h0;
         ptr_s_r   <= 3'h0;
         arm_s_r   <= 2'h0;
         pin_s_r   <= 2'h0;
      end else begin
         stop_s_r  <= {stop_s_r[1:0], stop_tgl_r};
         start_s_r <= {start_s_r[1:0], start_tgl_r};
         ptr_s_r   <= {ptr_s_r[1:0], ptr_tgl_r};
         arm_s_r   <= {arm_s_r[0], arm_r};
         pin_s_r   <= {pin_s_r[0], lnk.addr_pin};
      end
   end

   // Address pin level caught once after reset release
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cap_cnt_r  <= 2'h0;
         cap_done_r <= 1'b0;
         a0_r       <= 1'b0;
      end else if (!cap_done_r) begin
         cap_cnt_r <= cap_cnt_r + 2'h1;
         if (cap_cnt_r == 2'h3) begin
            a0_r       <= pin_s_r[1]; // R1
            cap_done_r <= 1'b1;
         end
      end
   end

   // Commit a write on STOP after the data acknowledge
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         done_r    <= 1'b0;
         reg_wr_r  <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
      end else begin
         reg_wr_r <= 1'b0;
         if (!arm_s_r[1]) begin
            done_r <= 1'b0;
         end else if (start_s_r[2] != start_s_r[1]) begin
            done_r <= 1'b1; // R7 R16
         end else if (stop_s_r[2] != stop_s_r[1] && !done_r) begin
            done_r    <= 1'b1; // R7
            reg_wr_r  <= 1'b1;
            wr_addr_r <= ptr_r;
            wr_data_r <= wdata_r;
         end
      end
   end

   // Pointer view for register reads
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_addr_r <= smp_pkg::PTR_RST;
         rd_word_r  <= 8'h00;
      end else begin
         rd_word_r <= reg_rdata;
         if (ptr_s_r[2] != ptr_s_r[1]) begin
            reg_addr_r <= ptr_r; // R11
         end
      end
   end

   // Address pin as open-drain reset pulse, alert or chain output
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pulse_cnt_r <= 20'h0_0000;
         pin_oe_r    <= 1'b0;
      end else begin
         if (pulse_req && cap_done_r) begin
            pulse_cnt_r <= 20'(RESET_PULSE_CYC); // R3
         end else if (pulse_cnt_r != 20'h0_0000) begin
            pulse_cnt_r <= pulse_cnt_r - 20'h0_0001;
         end
         pin_oe_r <= cap_done_r && ((pulse_cnt_r != 20'h0_0000) ||
                     alert_in || (chain_mode && !chain_val)); // R3
      end
   end

   assign lnk.sda_dev_oe  = sda_oe_r;
   assign lnk.addr_pin_oe = pin_oe_r;
   assign reg_addr        = reg_addr_r;
   assign reg_wr          = reg_wr_r;
   assign reg_wr_addr     = wr_addr_r;
   assign reg_wr_data     = wr_data_r;
   assign addr_bit        = a0_r;

endmodule : smp_dev_port
`default_nettype wire

// file: design/smp_pkg.sv
package smp_pkg;

   // Fixed upper six bits of the slave address and the general call address
   localparam logic [5:0] SLV_ADDR_HI  = 6'h16;
   localparam logic [6:0] GEN_CALL     = 7'h00;

   // Span of defined monitor register addresses and pointer reset value
   localparam logic [7:0] REG_LO       = 8'h20;
   localparam logic [7:0] REG_HI       = 8'h4F;
   localparam logic [7:0] PTR_RST      = 8'h20;

   // Bit positions inside one byte slot
   localparam logic [2:0] BIT_LAST     = 3'h7;
   localparam logic [3:0] ACK_SLOT     = 4'h8;

   // Clock rate and derived timing counts
   localparam int CLK_HZ        = 40_000_000;
   localparam int RST_PULSE_MS  = 20;
   localparam int RST_PULSE_CYC = (RST_PULSE_MS * CLK_HZ + 999) / 1000;
   localparam int SCL_HZ        = 100_000;
   localparam int QTR_CYC       = CLK_HZ / (4 * SCL_HZ);

   // Transaction kinds offered by the host command port
   typedef enum logic [1:0] {
      KIND_WRITE,
      KIND_READ,
      KIND_SEND,
      KIND_RECV
   } smp_kind_type;

   // Host bus operations, one per segment of a transaction
   typedef enum logic [1:0] {
      OP_START,
      OP_TX,
      OP_RX,
      OP_STOP
   } smp_op_type;

   // True for register addresses inside the defined set
   function automatic logic reg_valid(input logic [7:0] addr);
      return (addr >= REG_LO) && (addr <= REG_HI);
   endfunction : reg_valid

endpackage : smp_pkg

// file: design/smp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smp_link_if;
   logic scl;           // Link clock, driven by the host
   logic sda_host_oe;   // Host pulls the data line low
   logic sda_dev_oe;    // Device pulls the data line low
   logic sda;           // Resolved open-drain data line
   logic addr_pin_oe;   // Device pulls the address select pin low
   logic addr_pin_pull; // External strap level of the address select pin
   logic addr_pin;      // Resolved address select pin level

   // Wired-AND resolution of the open-drain lines
   assign sda      = ~(sda_host_oe | sda_dev_oe);
   assign addr_pin = addr_pin_pull & ~addr_pin_oe;

   modport device (
      input  scl,
      input  sda,
      input  addr_pin,
      output sda_dev_oe,
      output addr_pin_oe
   );

   modport host (
      output scl,
      output sda_host_oe,
      input  sda
   );
endinterface : smp_link_if
`default_nettype wire

// file: design/smp_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module smp_host_port (
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   smp_link_if.host                  lnk,
   input  wire logic                 cmd_valid,
   input  wire smp_pkg::smp_kind_type cmd_kind,
   input  wire logic [6:0]           cmd_addr,
   input  wire logic [7:0]           cmd_reg,
   input  wire logic [7:0]           cmd_wdata,
   output logic                      cmd_ready,
   output logic                      done,
   output logic                      nack,
   output logic [7:0]                rd_data
);

   smp_pkg::smp_kind_type kind_r;
   smp_pkg::smp_op_type   op_now;
   logic [6:0]  addr_r;
   logic [7:0]  reg_r;
   logic [7:0]  wdata_r;
   logic [7:0]  rx_r;
   logic [7:0]  tx_byte;
   logic [2:0]  seg_r;
   logic [3:0]  bit_r;
   logic [1:0]  q_r;
   logic [7:0]  div_r;
   logic        qtick_r;
   logic        abort_r;
   logic        scl_r;
   logic        sda_oe_r;
   logic        sda_s1_r;
   logic        sda_s2_r;
   logic        ready_r;
   logic        done_r;
   logic        nack_r;
   logic [7:0]  rd_data_r;

   // Operation for each segment of each transaction kind
   function automatic smp_pkg::smp_op_type seg_op(
      input smp_pkg::smp_kind_type kind,
      input logic [2:0]            seg
   );
      smp_pkg::smp_op_type op;
      op = smp_pkg::OP_TX;
      if (seg == 3'h0) begin
         op = smp_pkg::OP_START;
      end else begin
         case (kind)
            smp_pkg::KIND_WRITE: if (seg == 3'h4) op = smp_pkg::OP_STOP;
            smp_pkg::KIND_SEND:  if (seg == 3'h3) op = smp_pkg::OP_STOP;
            smp_pkg::KIND_RECV: begin
               if (seg == 3'h2) op = smp_pkg::OP_RX;
               if (seg == 3'h3) op = smp_pkg::OP_STOP;
            end
            default: begin
               if (seg == 3'h3) op = smp_pkg::OP_START;
               if (seg == 3'h5) op = smp_pkg::OP_RX;
               if (seg == 3'h6) op = smp_pkg::OP_STOP;
            end
         endcase
      end
      return op;
   endfunction : seg_op

   // Current operation and byte to send, MSB first
   always_comb begin
      op_now = abort_r ? smp_pkg::OP_STOP : seg_op(kind_r, seg_r);
      case (seg_r)
         3'h1:    tx_byte = {addr_r, kind_r == smp_pkg::KIND_RECV};
         3'h2:    tx_byte = reg_r;
         3'h3:    tx_byte = wdata_r;
         default: tx_byte = {addr_r, 1'b1};
      endcase
   end

   // Data line sampled through two flops
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
      end else begin
         sda_s1_r <= lnk.sda;
         sda_s2_r <= sda_s1_r;
      end
   end

   // Quarter-bit tick divider, runs only while busy
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         div_r   <= 8'h00;
         qtick_r <= 1'b0;
      end else if (ready_r || div_r == 8'(smp_pkg::QTR_CYC - 1)) begin
         div_r   <= 8'h00;
         qtick_r <= ~ready_r;
      end else begin
         div_r   <= div_r + 8'h01;
         qtick_r <= 1'b0;
      end
   end

   // Command accept and bus sequencer
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         kind_r    <= smp_pkg::KIND_WRITE;
         addr_r    <= 7'h00;
         reg_r     <= 8'h00;
         wdata_r   <= 8'h00;
         rx_r      <= 8'h00;
         seg_r     <= 3'h0;
         bit_r     <= 4'h0;
         q_r       <= 2'h0;
         abort_r   <= 1'b0;
         scl_r     <= 1'b1;
         sda_oe_r  <= 1'b0;
         ready_r   <= 1'b1;
         done_r    <= 1'b0;
         nack_r    <= 1'b0;
         rd_data_r <= 8'h00;
      end else if (ready_r) begin
         done_r <= 1'b0;
         if (cmd_valid) begin
            kind_r  <= cmd_kind;
            addr_r  <= cmd_addr;
            reg_r   <= cmd_reg;
            wdata_r <= cmd_wdata;
            seg_r   <= 3'h0;
            bit_r   <= 4'h0;
            q_r     <= 2'h0;
            abort_r <= 1'b0;
            nack_r  <= 1'b0;
            ready_r <= 1'b0;
         end
      end else if (qtick_r) begin
         q_r <= q_r + 2'h1;
         case (op_now)
            smp_pkg::OP_START: begin
               // Release, clock high, data falls while clock high
               case (q_r)
                  2'h0:    sda_oe_r <= 1'b0;
                  2'h1:    scl_r    <= 1'b1;
                  2'h2:    sda_oe_r <= 1'b1;
                  default: scl_r    <= 1'b0;
               endcase
            end
            smp_pkg::OP_STOP: begin
               // Data low, clock high, data rises while clock high
               case (q_r)
                  2'h0:    sda_oe_r <= 1'b1;
                  2'h1:    scl_r    <= 1'b1;
                  2'h2:    sda_oe_r <= 1'b0;
                  default: begin
                     ready_r   <= 1'b1;
                     done_r    <= 1'b1;
                     rd_data_r <= rx_r;
                  end
               endcase
            end
            default: begin
               case (q_r)
                  2'h0: begin // R6
                     sda_oe_r <= (op_now == smp_pkg::OP_TX) &&
                                 (bit_r != smp_pkg::ACK_SLOT) &&
                                 !tx_byte[3'(4'h7 - bit_r)];
                  end
                  2'h1: scl_r <= 1'b1;
                  2'h2: begin
                     if (bit_r != smp_pkg::ACK_SLOT) begin
                        rx_r <= {rx_r[6:0], sda_s2_r};
                     end else if (op_now == smp_pkg::OP_TX && sda_s2_r) begin
                        nack_r <= 1'b1;
                     end
                  end
                  default: begin
                     scl_r <= 1'b0;
                     if (bit_r == smp_pkg::ACK_SLOT) begin
                        // Abort only once the clock is low, so a real STOP follows
                        abort_r <= nack_r;
                        bit_r <= 4'h0;
                        seg_r <= seg_r + 3'h1;
                     end else begin
                        bit_r <= bit_r + 4'h1;
                     end
                  end
               endcase
            end
         endcase
         if (q_r == 2'h3 && op_now == smp_pkg::OP_START) begin
            seg_r <= seg_r + 3'h1;
         end
      end
   end

   assign lnk.scl         = scl_r;
   assign lnk.sda_host_oe = sda_oe_r;
   assign cmd_ready       = ready_r;
   assign done            = done_r;
   assign nack            = nack_r;
   assign rd_data         = rd_data_r;

endmodule : smp_host_port
`default_nettype wire

// file: testbench/smp_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module smp_link_props (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_dev_oe,
   input wire logic addr_pin,
   input wire logic addr_pin_oe
);
   logic [3:0] cnt_r;
   logic [2:0] byte_r;
   logic [2:0] rst_cnt_r;
   logic [7:0] shift_r;
   logic       a0_r;
   logic       rw_r;
   logic       addr_ok_r;
   logic       reg_ok_r;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // Bit slot and byte index inside the current frame
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r  <= 4'h0;
         byte_r <= 3'h0;
      end else if (scl && $fell(sda)) begin
         // The START's own clock fall brings the slot count to zero
         cnt_r  <= 4'hF;
         byte_r <= 3'h0;
      end else if ($fell(scl)) begin
         cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
         if (cnt_r == 4'h8 && byte_r != 3'h7) begin
            byte_r <= byte_r + 3'h1;
         end
      end
   end

   // Received byte and the verdicts the slave should reach
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_r   <= 8'h00;
         rw_r      <= 1'b0;
         addr_ok_r <= 1'b0;
         reg_ok_r  <= 1'b0;
      end else if ($rose(scl)) begin
         if (cnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda};
         end else if (byte_r == 3'h0) begin
            rw_r      <= shift_r[0];
            addr_ok_r <= shift_r == {smp_pkg::SLV_ADDR_HI, a0_r, 1'b0};
         end else if (byte_r == 3'h1) begin
            reg_ok_r <= addr_ok_r && shift_r >= smp_pkg::REG_LO
                        && shift_r <= smp_pkg::REG_HI;
         end
      end
   end

   // Strap level seen shortly after reset
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rst_cnt_r <= 3'h0;
         a0_r      <= 1'b0;
      end else if (rst_cnt_r != 3'h7) begin
         rst_cnt_r <= rst_cnt_r + 3'h1;
         if (rst_cnt_r == 3'h3) begin
            a0_r <= addr_pin;
         end
      end
   end

   chk_addr_ack: assert property (scl && cnt_r == 4'h8 && byte_r == 3'h0
      |-> sda_dev_oe == (shift_r[7:1] == {smp_pkg::SLV_ADDR_HI, a0_r}))
      else $error("address acknowledge wrong");
   chk_reg_ack: assert property (scl && cnt_r == 4'h8 && byte_r == 3'h1
      && addr_ok_r |-> sda_dev_oe == (shift_r >= smp_pkg::REG_LO
      && shift_r <= smp_pkg::REG_HI)) else $error("register acknowledge wrong");
   chk_data_ack: assert property (scl && cnt_r == 4'h8 && byte_r == 3'h2
      && reg_ok_r |-> sda_dev_oe) else $error("data byte not acknowledged");
   chk_drive_slots: assert property (scl && sda_dev_oe && cnt_r != 4'h8
      |-> rw_r && byte_r == 3'h1) else $error("data line driven out of slot");
   chk_host_nack_free: assert property (scl && cnt_r == 4'h8
      && byte_r == 3'h1 && rw_r |-> !sda_dev_oe)
      else $error("read acknowledge slot not released");
   chk_change_low: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("data line moved while clock high");
   chk_stop_idle: assert property (scl && $rose(sda) |=> !sda_dev_oe [*8])
      else $error("driving after stop");
   chk_pin_quiet: assert property (rst_cnt_r < 3'h4 |-> !addr_pin_oe)
      else $error("address pin driven before capture");

   cover property (scl && cnt_r == 4'h8 && byte_r == 3'h2 && sda_dev_oe);
   cover property (scl && rw_r && byte_r == 3'h1 && sda_dev_oe);
   cover property (scl && cnt_r == 4'h8 && byte_r == 3'h0 && !sda_dev_oe);
endmodule : smp_link_props
`default_nettype wire

// file: testbench/test_smbus_monitor_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_smbus_monitor_slave_port;
   logic                  mclk, sys_rst, cmd_valid, cmd_ready, done, nack;
   logic                  reg_wr, addr_bit, pulse_req, alert_in;
   logic                  chain_mode, chain_val, pin0;
   smp_pkg::smp_kind_type cmd_kind;
   logic [6:0]            cmd_addr, adr;
   logic [7:0]            cmd_reg, cmd_wdata, rd_data, reg_addr, reg_rdata;
   logic [7:0]            reg_wr_addr, reg_wr_data, ptr, r1;
   logic [7:0]            regs [256];
   logic [7:0]            mem [256];
   logic [7:0]            bw [4];
   int                    error_cnt = 0, compares = 0, wr_cnt = 0, wbits = 0;

   smp_link_if lnk ();

   smp_host_port smp_host_port_i (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk),
      .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
      .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .done(done), .nack(nack), .rd_data(rd_data));

   smp_dev_port #(.RESET_PULSE_CYC(50)) smp_dev_port_i (.mclk(mclk),
      .sys_rst(sys_rst), .lnk(lnk), .reg_addr(reg_addr),
      .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .addr_bit(addr_bit), .pulse_req(pulse_req),
      .alert_in(alert_in), .chain_mode(chain_mode), .chain_val(chain_val));

   smp_link_props smp_link_props_i (.mclk(mclk), .sys_rst(sys_rst),
      .scl(lnk.scl), .sda(lnk.sda), .sda_dev_oe(lnk.sda_dev_oe),
      .addr_pin(lnk.addr_pin), .addr_pin_oe(lnk.addr_pin_oe));

   // Clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // Monitor register file on the device user side
   always @(posedge mclk) begin
      if (reg_wr === 1'b1) begin
         regs[reg_wr_addr] <= reg_wr_data;
         wr_cnt <= wr_cnt + 1;
      end
   end
   always @(negedge mclk) reg_rdata <= regs[reg_addr];

   // Wire bytes of the current frame, restarted at every start
   always @(negedge lnk.sda) if (lnk.scl === 1'b1) wbits = 0;
   always @(posedge lnk.scl) begin
      if (wbits < 36 && wbits % 9 < 8) bw[wbits/9] = {bw[wbits/9][6:0], lnk.sda};
      wbits++;
   end

   task automatic chk(input logic c, input string m);
      compares++;
      if (c !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk

   task automatic results();
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   task automatic do_reset(input logic p);
      sys_rst = 1'b1;
      lnk.addr_pin_pull = p;
      repeat (10) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (8) @(negedge mclk);
      pin0 = p;
      ptr = smp_pkg::PTR_RST;
   endtask : do_reset

   // One host command, then the model's verdict against the design
   task automatic run(input smp_pkg::smp_kind_type k, input logic [6:0] a,
                      input logic [7:0] r, input logic [7:0] d);
      int   n0;
      int   i;
      logic rd;
      logic ok;
      logic hit;
      n0 = wr_cnt;
      rd = (k == smp_pkg::KIND_READ) || (k == smp_pkg::KIND_RECV);
      ok = (a == {smp_pkg::SLV_ADDR_HI, pin0});
      hit = ok && r >= smp_pkg::REG_LO && r <= smp_pkg::REG_HI;
      cmd_valid = 1'b1;
      cmd_kind = k;
      cmd_addr = a;
      cmd_reg = r;
      cmd_wdata = d;
      @(negedge mclk);
      cmd_valid = 1'b0;
      i = 0;
      while (done !== 1'b1 && i < 20000) begin
         @(negedge mclk);
         i++;
      end
      chk(i < 20000, "no completion");
      if (i >= 20000) results();
      if (hit && k != smp_pkg::KIND_RECV) ptr = r;
      if (hit && k == smp_pkg::KIND_WRITE) mem[r] = d;
      chk(nack === (k == smp_pkg::KIND_RECV ? !ok : !hit), "acknowledge");
      chk(wr_cnt == n0 + int'(hit && k == smp_pkg::KIND_WRITE), "writes");
      if (hit || !ok || rd) chk(reg_addr === ptr, "pointer");
      chk(regs[ptr] === mem[ptr], "register");
      chk(bw[0] === {a, rd}, "address byte");
      if (rd && ok) begin
         chk(rd_data === mem[ptr], "read data");
         chk(bw[1] === mem[ptr], "wire data");
      end
   endtask : run

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_kind = smp_pkg::KIND_WRITE;
      cmd_addr = 7'h00;
      cmd_reg = 8'h00;
      cmd_wdata = 8'h00;
      pulse_req = 1'b0;
      alert_in = 1'b0;
      chain_mode = 1'b0;
      chain_val = 1'b0;
      lnk.addr_pin_pull = 1'b1;
      void'($urandom(51));
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'($urandom);
         regs[i] = mem[i];
      end
      do_reset(1'b1);
      adr = {smp_pkg::SLV_ADDR_HI, 1'b1};
      chk(addr_bit === 1'b1, "address bit");
      r1 = smp_pkg::REG_LO + 8'($urandom % 48);
      run(smp_pkg::KIND_WRITE, adr, r1, 8'($urandom));
      run(smp_pkg::KIND_WRITE, adr, smp_pkg::REG_HI + 8'h01, 8'h5A);
      run(smp_pkg::KIND_READ, adr, r1, 8'h00);
      run(smp_pkg::KIND_SEND, adr, smp_pkg::REG_HI, 8'h00);
      run(smp_pkg::KIND_RECV, adr, 8'h00, 8'h00);
      run(smp_pkg::KIND_RECV, adr, 8'h00, 8'h00);
      run(smp_pkg::KIND_RECV, {smp_pkg::SLV_ADDR_HI, 1'b0}, 8'h00, 8'h00);
      run(smp_pkg::KIND_RECV, smp_pkg::GEN_CALL, 8'h00, 8'h00);
      // Shared address pin as an open-drain output
      alert_in = 1'b1;
      repeat (4) @(negedge mclk);
      chk(lnk.addr_pin === 1'b0, "alert drive");
      alert_in = 1'b0;
      chain_mode = 1'b1;
      repeat (4) @(negedge mclk);
      chk(lnk.addr_pin === 1'b0, "chain low");
      chain_val = 1'b1;
      repeat (4) @(negedge mclk);
      chk(lnk.addr_pin === 1'b1, "chain high");
      chain_mode = 1'b0;
      pulse_req = 1'b1;
      @(negedge mclk);
      pulse_req = 1'b0;
      repeat (10) @(negedge mclk);
      chk(lnk.addr_pin === 1'b0, "pulse low");
      repeat (60) @(negedge mclk);
      chk(lnk.addr_pin === 1'b1, "pulse end");
      // Strap low selects the other address
      do_reset(1'b0);
      chk(addr_bit === 1'b0, "address bit low");
      run(smp_pkg::KIND_RECV, {smp_pkg::SLV_ADDR_HI, 1'b0}, 8'h00, 8'h00);
      run(smp_pkg::KIND_RECV, adr, 8'h00, 8'h00);
      results();
   end
endmodule : test_smbus_monitor_slave_port
`default_nettype wire
